// ==== verilog/acmp_params.svh ====
// Register offsets, field positions and reset values of the comparator control block
`ifndef ACMP_PARAMS_SVH
`define ACMP_PARAMS_SVH
`define ACMP_OFF_CSR        12'h000
`define ACMP_OFF_SFR        12'h004
`define ACMP_OFF_IRQ_STAT   12'h008
`define ACMP_OFF_IRQ_MASK   12'h00c
`define ACMP_OFF_VEC_ACK    12'h010
`define ACMP_BIT_DISABLE    7
`define ACMP_BIT_BANDGAP    6
`define ACMP_BIT_OUTPUT     5
`define ACMP_BIT_FLAG       4
`define ACMP_BIT_IRQ_EN     3
`define ACMP_BIT_CAPTURE    2
`define ACMP_BIT_MODE_HI    1
`define ACMP_BIT_MODE_LO    0
`define ACMP_BIT_MUX_EN     3
`define ACMP_CSR_RESET      8'h00
`define ACMP_SFR_RESET      8'h00
`define ACMP_SYNC_STAGES    2
`endif

// ==== verilog/acmp_pkg.sv ====
// Types shared by the comparator control block
package acmp_pkg;
   typedef enum logic [1:0]
   {
      ACMP_EV_TOGGLE   = 2'b00,
      ACMP_EV_RESERVED = 2'b01,
      ACMP_EV_FALL     = 2'b10,
      ACMP_EV_RISE     = 2'b11
   } acmp_mode_t;
endpackage

// ==== verilog/acmp_sync.sv ====
// Two-stage level synchroniser
`timescale 1ns/1ps
module acmp_sync
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic ce,
   input  wire logic d,
   output logic      q
);
   logic meta_q;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= 1'b0;
         q      <= 1'b0;
      end
      else if (ce)
      begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule

// ==== verilog/acmp_top.sv ====
// Comparator control logic with APB register access
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
`include "acmp_params.svh"
// Function
// RULE_01 - Writing one to disable bit powers comparator down; zero powers it up
// RULE_02 - Software clears interrupt enable before changing the disable bit
// RULE_03 - Bandgap select picks bandgap reference, otherwise positive pin, as positive input
// RULE_04 - Output status bit is comparator result synchronised, one to two cycles late
// RULE_05 - Event flag sets on the event chosen by the mode field
// RULE_06 - Interrupt only when flag, enable and global enable are all one; the irq output instead follows masked status in stat_q
// RULE_07 - Flag clears automatically when the interrupt vector is executed
// RULE_08 - Writing one to the flag clears it; zero leaves it
// RULE_09 - Capture route enable connects comparator output to timer capture front end
// RULE_10 - Software also sets capture interrupt enable in the timer mask
// RULE_11 - Mode 00 toggle, 10 falling, 11 rising, 01 reserved
// RULE_12 - Software clears interrupt enable before altering the mode field
// RULE_13 - Mux enable with converter off routes channel pin chosen by channel select
// RULE_14 - Otherwise the negative input pin drives the negative input
// RULE_15 - Result is one when positive input exceeds negative input
// RULE_16 - Mux enable sits at bit 3 of shared register, read/write, reset zero
// RULE_17 - Edges found by comparing successive synchronised samples, one set per edge
// RULE_18 - Converter enable and channel select are inputs; selection and output exported
module acmp_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        cmp_result,
   input  wire logic        global_irq_enable,
   input  wire logic        converter_enable,
   input  wire logic [2:0]  channel_select,
   output logic             comparator_power_down,
   output logic             positive_sel_bandgap,
   output logic             negative_sel_channel,
   output logic      [2:0]  negative_channel,
   output logic             capture_trigger,
   output logic             capture_route_active,
   output logic             comparator_irq,
   output logic             irq
);
   import acmp_pkg::*;

   logic [7:0] csr_q;
   logic       mux_en_q;
   logic       flag_q;
   logic [1:0] stat_q;
   logic [1:0] mask_q;
   logic       cmp_sync;
   logic       cmp_prev_q;
   logic       event_hit;
   logic       wr_acc;
   logic       rd_acc;
   logic       addr_ok;
   logic       flag_w1c;
   logic       vec_ack;
   logic       irq_req;
   logic       stat_pend;
   logic [1:0] warm_q;
   logic       edge_ok;
   logic [7:0] csr_rd;
   acmp_mode_t mode;

   // Reset value of the shared register, so the mux enable bit can be picked out of it
   localparam logic [7:0] SFR_RESET_VAL = `ACMP_SFR_RESET;

   assign mode    = acmp_mode_t'(csr_q[`ACMP_BIT_MODE_HI:`ACMP_BIT_MODE_LO]);
   assign addr_ok = (paddr == `ACMP_OFF_CSR) || (paddr == `ACMP_OFF_SFR)
                 || (paddr == `ACMP_OFF_IRQ_STAT) || (paddr == `ACMP_OFF_IRQ_MASK)
                 || (paddr == `ACMP_OFF_VEC_ACK);
   // Zero-wait slave: each access phase completes in its first cycle
   assign wr_acc  = psel && penable && pwrite && addr_ok && pstrb[0];
   assign rd_acc  = psel && penable && !pwrite && addr_ok;

   // The analog pin is asynchronous to pclk
   acmp_sync u_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .d       (cmp_result), // RULE_15
      .q       (cmp_sync)    // RULE_04
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cmp_prev_q <= 1'b0;
      else if (ce)
         cmp_prev_q <= cmp_sync; // RULE_17
   end

   // Edges count only once both samples hold real pin data, so a comparator
   // that is already high when reset ends does not look like a rising edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         warm_q <= 2'h0;
      else if (ce && warm_q != 2'h3)
         warm_q <= warm_q + 2'h1;
   end

   assign edge_ok = (warm_q == 2'h3);

   // Reserved mode never sets the flag
   always_comb
   begin
      unique case (mode)
         ACMP_EV_TOGGLE:   event_hit = cmp_sync ^ cmp_prev_q; // RULE_11
         ACMP_EV_RESERVED: event_hit = 1'b0;
         ACMP_EV_FALL:     event_hit = cmp_prev_q && !cmp_sync;
         ACMP_EV_RISE:     event_hit = !cmp_prev_q && cmp_sync;
      endcase
      if (!edge_ok)
         event_hit = 1'b0; // RULE_17
   end

   // Control bits of the main register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         csr_q <= `ACMP_CSR_RESET;
      else if (ce && wr_acc && paddr == `ACMP_OFF_CSR)
         csr_q <= pwdata[7:0]; // RULE_01
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mux_en_q <= SFR_RESET_VAL[`ACMP_BIT_MUX_EN];
      else if (ce && wr_acc && paddr == `ACMP_OFF_SFR)
         mux_en_q <= pwdata[`ACMP_BIT_MUX_EN]; // RULE_16
   end

   assign flag_w1c = wr_acc && paddr == `ACMP_OFF_CSR && pwdata[`ACMP_BIT_FLAG];
   assign vec_ack  = wr_acc && paddr == `ACMP_OFF_VEC_ACK && pwdata[0];

   // A new event in the clearing cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         flag_q <= 1'b0;
      else if (ce)
      begin
         if (event_hit)
            flag_q <= 1'b1; // RULE_05
         else if (flag_w1c || vec_ack)
            flag_q <= 1'b0; // RULE_08 RULE_07
      end
   end

   assign irq_req = flag_q && csr_q[`ACMP_BIT_IRQ_EN] && global_irq_enable; // RULE_06
   assign stat_pend = |(stat_q & mask_q);

   // Sticky status: bit 0 comparator event, bit 1 capture trigger edge; read clears
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         stat_q <= 2'b00;
      else if (ce)
      begin
         stat_q[0] <= event_hit
                   || (stat_q[0] && !(rd_acc && paddr == `ACMP_OFF_IRQ_STAT));
         stat_q[1] <= (csr_q[`ACMP_BIT_CAPTURE] && edge_ok && (cmp_sync ^ cmp_prev_q))
                   || (stat_q[1] && !(rd_acc && paddr == `ACMP_OFF_IRQ_STAT));
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         mask_q <= 2'b00;
      else if (ce && wr_acc && paddr == `ACMP_OFF_IRQ_MASK)
         mask_q <= pwdata[1:0];
   end

   // Output and flag bits read from live state, not from what was last written
   always_comb
   begin
      csr_rd                   = csr_q;
      csr_rd[`ACMP_BIT_OUTPUT] = cmp_sync; // RULE_04
      csr_rd[`ACMP_BIT_FLAG]   = flag_q;
   end

   // Registered read data and response
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata  <= 32'h0000_0000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
      else if (ce)
      begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !addr_ok;
         prdata  <= 32'h0000_0000;
         if (psel && !penable && !pwrite)
         begin
            unique case (paddr)
               `ACMP_OFF_CSR:
                  prdata <= {24'h00_0000, csr_rd};
               `ACMP_OFF_SFR:
                  prdata <= {28'h000_0000, mux_en_q, 3'h0};
               `ACMP_OFF_IRQ_STAT:
                  prdata <= {30'h0000_0000, stat_q};
               `ACMP_OFF_IRQ_MASK:
                  prdata <= {30'h0000_0000, mask_q};
               default:
                  prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Analog control and timer-facing outputs, all registered
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         comparator_power_down <= 1'b0;
         positive_sel_bandgap  <= 1'b0;
         negative_sel_channel  <= 1'b0;
         negative_channel      <= 3'h0;
         capture_trigger       <= 1'b0;
         capture_route_active  <= 1'b0;
         comparator_irq        <= 1'b0;
         irq                   <= 1'b0;
      end
      else if (ce)
      begin
         comparator_power_down <= csr_q[`ACMP_BIT_DISABLE]; // RULE_01
         positive_sel_bandgap  <= csr_q[`ACMP_BIT_BANDGAP]; // RULE_03
         negative_sel_channel  <= mux_en_q && !converter_enable; // RULE_13 RULE_14
         negative_channel      <= (mux_en_q && !converter_enable) ? channel_select : 3'h0;
         capture_trigger       <= csr_q[`ACMP_BIT_CAPTURE] && cmp_sync; // RULE_09 RULE_18
         capture_route_active  <= csr_q[`ACMP_BIT_CAPTURE];
         comparator_irq        <= irq_req;
         irq                   <= stat_pend;
      end
   end

   // Flag stays up until a clear arrives
   a_flag_sets: assert property ( // RULE_05
      @(posedge pclk) disable iff (!presetn)
      ce && event_hit |=> flag_q)
      else $error("flag did not set after event");
   a_flag_w1c: assert property ( // RULE_08
      @(posedge pclk) disable iff (!presetn)
      ce && flag_w1c && !event_hit |=> !flag_q)
      else $error("write one did not clear flag");
   a_vec_clear: assert property ( // RULE_07
      @(posedge pclk) disable iff (!presetn)
      ce && vec_ack && !event_hit |=> !flag_q)
      else $error("vector ack did not clear flag");
   a_irq_gate: assert property ( // RULE_06
      @(posedge pclk) disable iff (!presetn)
      ce |=> comparator_irq == $past(irq_req))
      else $error("comparator irq gating wrong");
   a_rise_only: assert property ( // RULE_11
      @(posedge pclk) disable iff (!presetn)
      mode == ACMP_EV_RISE && event_hit |-> cmp_sync && !cmp_prev_q)
      else $error("rise mode hit without rising edge");
   a_fall_only: assert property ( // RULE_11
      @(posedge pclk) disable iff (!presetn)
      mode == ACMP_EV_FALL && event_hit |-> !cmp_sync && cmp_prev_q)
      else $error("fall mode hit without falling edge");
   a_reserved_quiet: assert property ( // RULE_11
      @(posedge pclk) disable iff (!presetn)
      mode == ACMP_EV_RESERVED |-> !event_hit)
      else $error("reserved mode produced event");
   a_sync_delay: assert property ( // RULE_04
      @(posedge pclk) disable iff (!presetn)
      ce && $past(ce) && $past(ce, 2) |-> cmp_sync == $past(cmp_result, 2))
      else $error("synchroniser delay wrong");
   a_neg_select: assert property ( // RULE_14
      @(posedge pclk) disable iff (!presetn)
      ce && converter_enable |=> !negative_sel_channel)
      else $error("channel routed while converter on");
   a_neg_pin: assert property ( // RULE_14
      @(posedge pclk) disable iff (!presetn)
      ce && !mux_en_q |=> !negative_sel_channel && negative_channel == 3'h0)
      else $error("channel routed while mux disabled");
   a_chan_route: assert property ( // RULE_13
      @(posedge pclk) disable iff (!presetn)
      ce && mux_en_q && !converter_enable
      |=> negative_sel_channel && negative_channel == $past(channel_select))
      else $error("selected channel not routed");
   a_capture_off: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      ce && !csr_q[`ACMP_BIT_CAPTURE] |=> !capture_trigger)
      else $error("capture fed while route disabled");
   a_capture_feed: assert property ( // RULE_09
      @(posedge pclk) disable iff (!presetn)
      ce && csr_q[`ACMP_BIT_CAPTURE] |=> capture_trigger == $past(cmp_sync))
      else $error("capture not fed while route enabled");
   a_mux_reg: assert property ( // RULE_16
      @(posedge pclk) disable iff (!presetn)
      ce && wr_acc && paddr == `ACMP_OFF_SFR |=> mux_en_q == $past(pwdata[3]))
      else $error("mux enable not written");
   a_power_down: assert property ( // RULE_01
      @(posedge pclk) disable iff (!presetn)
      ce |=> comparator_power_down == $past(csr_q[`ACMP_BIT_DISABLE]))
      else $error("power down does not follow disable bit");
   a_bandgap_sel: assert property ( // RULE_03
      @(posedge pclk) disable iff (!presetn)
      ce |=> positive_sel_bandgap == $past(csr_q[`ACMP_BIT_BANDGAP]))
      else $error("positive input select does not follow bandgap bit");
   a_flag_hold: assert property ( // RULE_08
      @(posedge pclk) disable iff (!presetn)
      ce && flag_q && !flag_w1c && !vec_ack |=> flag_q)
      else $error("flag dropped without a clear");
   a_no_edge_set: assert property ( // RULE_17
      @(posedge pclk) disable iff (!presetn)
      ce && !event_hit && !flag_q |=> !flag_q)
      else $error("flag set without an edge");
   a_warm_quiet: assert property ( // RULE_17
      @(posedge pclk) disable iff (!presetn)
      !edge_ok |-> !event_hit)
      else $error("edge seen before samples were valid");
   a_stat_sticky: assert property ( // RULE_05
      @(posedge pclk) disable iff (!presetn)
      ce && event_hit |=> stat_q[0])
      else $error("status bit missed an event");
   a_irq_level: assert property ( // RULE_06
      @(posedge pclk) disable iff (!presetn)
      ce |=> irq == $past(stat_pend))
      else $error("irq does not follow masked status");
   a_apb_ready: assert property ( // APB handshake, decided locally
      @(posedge pclk) disable iff (!presetn)
      ce && psel && !penable |=> pready)
      else $error("apb ready missing");

   c_toggle: cover property (@(posedge pclk) disable iff (!presetn)
      mode == ACMP_EV_TOGGLE && event_hit);
   c_fall: cover property (@(posedge pclk) disable iff (!presetn)
      mode == ACMP_EV_FALL && event_hit);
   c_rise: cover property (@(posedge pclk) disable iff (!presetn)
      mode == ACMP_EV_RISE && event_hit);
   c_irq: cover property (@(posedge pclk) disable iff (!presetn) comparator_irq);
   c_set_clear: cover property (@(posedge pclk) disable iff (!presetn)
      event_hit && flag_w1c);
endmodule

// ==== verification/acmp_top_tb.sv ====
// Self-checking APB bench for the comparator control block
`timescale 1ns/1ps
`include "acmp_params.svh"
module acmp_top_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        cmp_result = 1'b0;
   logic        global_irq_enable = 1'b0;
   logic        converter_enable = 1'b0;
   logic        ce = 1'b1;
   logic [2:0]  channel_select = 3'h0;
   logic        power_down;
   logic        sel_bandgap;
   logic        sel_channel;
   logic [2:0]  neg_channel;
   logic        cap_trig;
   logic        cap_active;
   logic        cmp_irq;
   logic        irq;
   logic [31:0] rd;
   logic        err;
   logic [7:0]  expv;
   int          mismatches = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          m;

   always #5 pclk = ~pclk;

   acmp_top dut
   (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cmp_result(cmp_result),
      .global_irq_enable(global_irq_enable), .converter_enable(converter_enable),
      .channel_select(channel_select), .comparator_power_down(power_down),
      .positive_sel_bandgap(sel_bandgap), .negative_sel_channel(sel_channel),
      .negative_channel(neg_channel), .capture_trigger(cap_trig),
      .capture_route_active(cap_active), .comparator_irq(cmp_irq), .irq(irq)
   );

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Holds the request until pready is seen high, then idles one cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // No wait limit here: only the bench timeout may end a stalled access
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge pclk);
   endtask

   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         mismatches++;
         final_report();
      end
   end

   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      tick(1);
      rdchk(`ACMP_OFF_CSR, 32'h00);
      rdchk(`ACMP_OFF_SFR, 32'h00);
      apb(1'b1, `ACMP_OFF_CSR, 32'hc4);
      // Registered outputs launch on the edge the task returns on
      tick(1);
      chk(32'(power_down), 32'h1);
      chk(32'(sel_bandgap), 32'h1);
      chk(32'(cap_active), 32'h1);
      cmp_result <= 1'b1;
      tick(4);
      chk(32'(cap_trig), 32'h1);
      rdchk(`ACMP_OFF_CSR, 32'hf4);
      apb(1'b1, `ACMP_OFF_CSR, 32'h10);
      tick(1);
      chk(32'(power_down), 32'h0);
      chk(32'(sel_bandgap), 32'h0);
      chk(32'(cap_trig), 32'h0);
      chk(32'(cap_active), 32'h0);
      rdchk(`ACMP_OFF_CSR, 32'h20);
      // Reserved mode last: it must raise no flag on either edge
      for (int i = 0; i < 4; i++)
      begin
         m = (i == 0) ? 0 : (i == 1) ? 2 : (i == 2) ? 3 : 1;
         apb(1'b1, `ACMP_OFF_CSR, 32'(m) | 32'h10);
         cmp_result <= 1'b0;
         tick(4);
         expv = 8'(m) | ((m == 0 || m == 2) ? 8'h10 : 8'h00);
         rdchk(`ACMP_OFF_CSR, 32'(expv));
         apb(1'b1, `ACMP_OFF_CSR, 32'(m) | 32'h10);
         cmp_result <= 1'b1;
         tick(4);
         expv = 8'(m) | 8'h20 | ((m == 0 || m == 3) ? 8'h10 : 8'h00);
         rdchk(`ACMP_OFF_CSR, 32'(expv));
      end
      // Mode changes with the interrupt still off, then the enable alone
      apb(1'b1, `ACMP_OFF_CSR, 32'h13);
      apb(1'b1, `ACMP_OFF_CSR, 32'h1b);
      apb(1'b0, `ACMP_OFF_IRQ_STAT, 32'h0);
      global_irq_enable <= 1'b1;
      cmp_result <= 1'b0;
      tick(4);
      chk(32'(cmp_irq), 32'h0);
      cmp_result <= 1'b1;
      tick(5);
      chk(32'(cmp_irq), 32'h1);
      apb(1'b1, `ACMP_OFF_CSR, 32'h0b);
      rdchk(`ACMP_OFF_CSR, 32'h3b);
      global_irq_enable <= 1'b0;
      tick(3);
      chk(32'(cmp_irq), 32'h0);
      global_irq_enable <= 1'b1;
      apb(1'b1, `ACMP_OFF_VEC_ACK, 32'h1);
      rdchk(`ACMP_OFF_CSR, 32'h2b);
      chk(32'(cmp_irq), 32'h0);
      apb(1'b1, `ACMP_OFF_IRQ_MASK, 32'h3);
      tick(2);
      chk(32'(irq), 32'h1);
      rdchk(`ACMP_OFF_IRQ_STAT, 32'h1);
      tick(2);
      chk(32'(irq), 32'h0);
      rdchk(`ACMP_OFF_IRQ_STAT, 32'h0);
      apb(1'b1, `ACMP_OFF_SFR, 32'h08);
      rdchk(`ACMP_OFF_SFR, 32'h08);
      for (int ch = 0; ch < 8; ch++)
      begin
         channel_select <= 3'(ch);
         tick(3);
         chk(32'(sel_channel), 32'h1);
         chk(32'(neg_channel), 32'(ch));
      end
      converter_enable <= 1'b1;
      tick(3);
      chk(32'(sel_channel), 32'h0);
      chk(32'(neg_channel), 32'h0);
      converter_enable <= 1'b0;
      apb(1'b1, `ACMP_OFF_SFR, 32'h00);
      tick(2);
      chk(32'(sel_channel), 32'h0);
      rdchk(12'h020, 32'h0);
      chk(32'(err), 32'h1);
      // Clock enable low must freeze the synchroniser and the capture feed
      apb(1'b1, `ACMP_OFF_CSR, 32'h07);
      tick(4);
      chk(32'(cap_trig), 32'h1);
      ce <= 1'b0;
      cmp_result <= 1'b0;
      tick(4);
      chk(32'(cap_trig), 32'h1);
      ce <= 1'b1;
      tick(4);
      chk(32'(cap_trig), 32'h0);
      final_report();
   end
endmodule
